/* verilog/piu_defs.vh */
// Constants shared by the priority interrupt unit design files
`ifndef PIU_DEFS_VH
`define PIU_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PIU_ADDR_EXT0_CTL 8'h98
`define PIU_ADDR_EXT1_CTL 8'h99
`define PIU_ADDR_EXT_BASE 8'h9c
`define PIU_ADDR_INT_BASE 8'h9d
`define PIU_ADDR_PRI_STACK 8'h9e
`define PIU_ADDR_STATUS 8'h9f

// ----------------------------------------------------------------
// Field layout of the external control registers
// ----------------------------------------------------------------
`define PIU_CTL_PRI_LSB 0
`define PIU_CTL_PRI_MSB 1
`define PIU_CTL_FIRST_LSB 2
`define PIU_CTL_FIRST_MSB 3
`define PIU_CTL_SECOND_LSB 4
`define PIU_CTL_SECOND_MSB 5
`define PIU_CTL_W 6

// ----------------------------------------------------------------
// Edge selections and priority levels
// ----------------------------------------------------------------
`define PIU_EDGE_OFF 2'b00
`define PIU_EDGE_FALL 2'b01
`define PIU_EDGE_RISE 2'b10
`define PIU_EDGE_BOTH 2'b11
`define PIU_PRI_NONE 2'b00
`define PIU_PRI_W 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIU_PRI_STACK_RST 8'hff
`define PIU_BASE_RST 8'h00
`define PIU_CTL_RST 6'h00

// ----------------------------------------------------------------
// Sources and vectors
// ----------------------------------------------------------------
`define PIU_NUM_INT 12
`define PIU_NUM_SRC 14
`define PIU_SRC_EXT1 4'h0
`define PIU_SRC_EXT0 4'h1
`define PIU_SRC_INT_FIRST 4'h2
`define PIU_VEC_LO_EXT0 8'h00
`define PIU_VEC_LO_EXT1 8'h08
`define PIU_VEC_STEP_SHIFT 4
`define PIU_SP_HI_OFS 16'h0001
`define PIU_SP_LO_OFS 16'h0002

`endif

/* verilog/piu_catcher.v */
// Pulse catcher for one external interrupt pin
`timescale 1ns/100ps
`default_nettype none
`include "piu_defs.vh"

module piu_catcher
(
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    // Pin and control
    input wire pin_in,
    input wire [1:0] edge_sel,
    input wire clear,
    // Caught edge
    output wire caught
);

reg sync1_ff;
reg sync2_ff;
reg sync3_ff;
reg level_ff;
reg caught_ff;
wire agree;
wire rise;
wire fall;
reg hit;

// ----------------------------------------------------------------
// Three stage synchroniser, level changes when stages two and three agree
// ----------------------------------------------------------------
assign agree = (sync2_ff == sync3_ff);
assign rise = agree & sync3_ff & ~level_ff;
assign fall = agree & ~sync3_ff & level_ff;

always @*
begin
    case (edge_sel)
        `PIU_EDGE_RISE: hit = rise;
        `PIU_EDGE_FALL: hit = fall;
        `PIU_EDGE_BOTH: hit = rise | fall;
        default: hit = 1'b0;
    endcase
end

always @(posedge sys_clk or negedge rstn)
begin
    if (!rstn)
    begin
        sync1_ff <= 1'b0;
        sync2_ff <= 1'b0;
        sync3_ff <= 1'b0;
        level_ff <= 1'b0;
        caught_ff <= 1'b0;
    end
    else
    begin
        sync1_ff <= pin_in;
        sync2_ff <= sync1_ff;
        sync3_ff <= sync2_ff;
        if (agree)
        begin
            level_ff <= sync3_ff;
        end
        // A new edge beats a clear in the same cycle
        caught_ff <= hit | (caught_ff & ~clear);
    end
end

assign caught = caught_ff;

endmodule // piu_catcher
`default_nettype wire

/* verilog/piu_top.v */
// Priority interrupt unit: arbitration, acknowledge sequence and vectors
//
// Operation
// - Taking an interrupt calls: pushes program counter, jumps to vector.
// - Fixed low byte per source; high byte from external or internal base.
// - Each base selects a 256-byte code table; internal entries 16 bytes apart, external at 00h and 08h.
// - Request above processor priority is taken after the current instruction.
// - Old priority pushed on four-deep stack; current set to request's.
// - Request dropped if its source latch clears before central capture.
// - Equal priority order: ext1, ext0, tick, quad, timer B, A, capture, ...
// - External request cleared only by its acknowledge cycle.
// - Tick, quad, timer and capture requests clear on status register read.
// - Port receive clears on data read; transmit on data or status write.
// - Two external interrupts, each from two pins with own pulse catcher.
// - Edge select: 00 off, 10 rising, 01 falling, 11 both.
// - Taking an external interrupt resets both of its pulse catchers.
// - Catchers watch the pin level even when the port drives it.
// - Acknowledge follows first-opcode fetch; that byte is fetched again.
// - Acknowledge is followed by two stack writes, then vector fetch.
// - Control register: bits 5:4 second pin, 3:2 first pin, 1:0 priority.
// - External 0 vectors at low byte 00h, external 1 at 08h.
// - Reset sets priority stack to all ones and both bases to zero.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "piu_defs.vh"

module piu_top
(
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    // External interrupt pins, sampled at the pad
    input wire irq_zero_first_pin,
    input wire irq_zero_second_pin,
    input wire irq_one_first_pin,
    input wire irq_one_second_pin,
    // Internal peripheral request latches and their priorities
    input wire [11:0] int_req,
    input wire [23:0] int_pri,
    // Processor sequencer
    input wire fetch1_done,
    input wire pri_pop,
    input wire [15:0] cpu_pc,
    input wire [15:0] cpu_sp,
    output wire ack_cycle,
    output wire ack_refetch,
    output wire mem_wr,
    output wire [15:0] mem_addr,
    output wire [7:0] mem_wdata,
    output wire sp_load,
    output wire [15:0] sp_value,
    output wire vector_valid,
    output wire [15:0] vector_addr,
    output wire [1:0] cur_priority
);

// ----------------------------------------------------------------
// States of the acknowledge sequence
// ----------------------------------------------------------------
localparam ST_IDLE = 3'b000;
localparam ST_ACK = 3'b001;
localparam ST_PUSH_HI = 3'b010;
localparam ST_PUSH_LO = 3'b011;
localparam ST_VECTOR = 3'b100;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [5:0] ext0_ctl_ff;
reg [5:0] ext1_ctl_ff;
reg [7:0] ext_base_ff;
reg [7:0] int_base_ff;
reg [7:0] pri_stack_ff;
reg [7:0] nxt_pri_stack;
reg [7:0] rdata_ff;
reg [3:0] win_src_ff;
reg [1:0] win_pri_ff;
reg mem_wr_ff;
reg [15:0] mem_addr_ff;
reg [7:0] mem_wdata_ff;
reg sp_load_ff;
reg [15:0] sp_value_ff;
reg vector_valid_ff;
reg [15:0] vector_addr_ff;
reg [15:0] pc_hold_ff;
wire [3:0] caught;
wire ext0_req;
wire ext1_req;
wire clr_ext0;
wire clr_ext1;
wire [1:0] cur_pri;
reg [`PIU_NUM_SRC-1:0] src_req;
reg [2*`PIU_NUM_SRC-1:0] src_pri;
reg best_valid;
reg [3:0] best_src;
reg [1:0] best_pri;
reg [7:0] vec_lo;
reg [7:0] vec_hi;
reg [3:0] int_idx;
integer k;

assign cur_pri = pri_stack_ff[`PIU_PRI_W-1:0];

// ----------------------------------------------------------------
// Pulse catchers, two per external interrupt
// ----------------------------------------------------------------
// Clears land in the acknowledge cycle of the matching source
assign clr_ext0 = (state_ff == ST_ACK) &
                  (win_src_ff == `PIU_SRC_EXT0);
assign clr_ext1 = (state_ff == ST_ACK) &
                  (win_src_ff == `PIU_SRC_EXT1);

// Pin inputs are pad levels, so a driven output bit still triggers
piu_catcher u_catch_zero_a
(
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(irq_zero_first_pin),
    .edge_sel(ext0_ctl_ff[`PIU_CTL_FIRST_MSB:`PIU_CTL_FIRST_LSB]),
    .clear(clr_ext0),
    .caught(caught[0])
);

piu_catcher u_catch_zero_b
(
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(irq_zero_second_pin),
    .edge_sel(ext0_ctl_ff[`PIU_CTL_SECOND_MSB:`PIU_CTL_SECOND_LSB]),
    .clear(clr_ext0),
    .caught(caught[1])
);

piu_catcher u_catch_one_a
(
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(irq_one_first_pin),
    .edge_sel(ext1_ctl_ff[`PIU_CTL_FIRST_MSB:`PIU_CTL_FIRST_LSB]),
    .clear(clr_ext1),
    .caught(caught[2])
);

piu_catcher u_catch_one_b
(
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(irq_one_second_pin),
    .edge_sel(ext1_ctl_ff[`PIU_CTL_SECOND_MSB:`PIU_CTL_SECOND_LSB]),
    .clear(clr_ext1),
    .caught(caught[3])
);

// Either pin of a pair raises one shared request
assign ext0_req = caught[0] | caught[1];
assign ext1_req = caught[2] | caught[3];

// ----------------------------------------------------------------
// Arbitration: level first, fixed source order second
// ----------------------------------------------------------------
always @*
begin
    src_req = {`PIU_NUM_SRC{1'b0}};
    src_pri = {(2*`PIU_NUM_SRC){1'b0}};
    // Index 0 is the highest in the fixed order
    src_req[`PIU_SRC_EXT1] = ext1_req;
    src_req[`PIU_SRC_EXT0] = ext0_req;
    src_pri[2*`PIU_SRC_EXT1 +: 2] =
        ext1_ctl_ff[`PIU_CTL_PRI_MSB:`PIU_CTL_PRI_LSB];
    src_pri[2*`PIU_SRC_EXT0 +: 2] =
        ext0_ctl_ff[`PIU_CTL_PRI_MSB:`PIU_CTL_PRI_LSB];
    // Internal latches are read live; a latch cleared early is gone
    src_req[`PIU_NUM_SRC-1:`PIU_SRC_INT_FIRST] = int_req;
    src_pri[2*`PIU_NUM_SRC-1:2*`PIU_SRC_INT_FIRST] = int_pri;
    best_valid = 1'b0;
    best_src = 4'h0;
    best_pri = `PIU_PRI_NONE;
    for (k = 0; k < `PIU_NUM_SRC; k = k + 1)
    begin
        // Strictly greater keeps the earlier source on a tie
        if (src_req[k] && (src_pri[2*k +: 2] != `PIU_PRI_NONE) &&
            (src_pri[2*k +: 2] > cur_pri) &&
            (!best_valid || (src_pri[2*k +: 2] > best_pri)))
        begin
            best_valid = 1'b1;
            best_src = k[3:0];
            best_pri = src_pri[2*k +: 2];
        end
    end
end

// ----------------------------------------------------------------
// Vector formation
// ----------------------------------------------------------------
always @*
begin
    int_idx = win_src_ff - `PIU_SRC_INT_FIRST;
    if (win_src_ff == `PIU_SRC_EXT0)
    begin
        vec_hi = ext_base_ff;
        vec_lo = `PIU_VEC_LO_EXT0;
    end
    else if (win_src_ff == `PIU_SRC_EXT1)
    begin
        vec_hi = ext_base_ff;
        vec_lo = `PIU_VEC_LO_EXT1;
    end
    else
    begin
        vec_hi = int_base_ff;
        // Entries 16 bytes apart inside one 256-byte code table
        vec_lo = {int_idx, 4'h0};
    end
end

// ----------------------------------------------------------------
// Acknowledge sequence
// ----------------------------------------------------------------
always @*
begin
    case (state_ff)
        ST_IDLE:
        begin
            // Capture only on a first-opcode fetch boundary
            if (fetch1_done && best_valid)
            begin
                nxt_state = ST_ACK;
            end
            else
            begin
                nxt_state = ST_IDLE;
            end
        end
        ST_ACK: nxt_state = ST_PUSH_HI;
        ST_PUSH_HI: nxt_state = ST_PUSH_LO;
        ST_PUSH_LO: nxt_state = ST_VECTOR;
        ST_VECTOR: nxt_state = ST_IDLE;
        default: nxt_state = ST_IDLE;
    endcase
end

always @*
begin
    nxt_pri_stack = pri_stack_ff;
    if (state_ff == ST_ACK)
    begin
        nxt_pri_stack = {pri_stack_ff[5:0], win_pri_ff};
    end
    else if (reg_wr && (reg_addr == `PIU_ADDR_PRI_STACK))
    begin
        nxt_pri_stack = reg_wdata;
    end
    else if (pri_pop)
    begin
        nxt_pri_stack = {2'b11, pri_stack_ff[7:2]};
    end
end

always @(posedge sys_clk or negedge rstn)
begin
    if (!rstn)
    begin
        state_ff <= ST_IDLE;
        win_src_ff <= 4'h0;
        win_pri_ff <= `PIU_PRI_NONE;
        pri_stack_ff <= `PIU_PRI_STACK_RST;
        pc_hold_ff <= 16'h0000;
        mem_wr_ff <= 1'b0;
        mem_addr_ff <= 16'h0000;
        mem_wdata_ff <= 8'h00;
        sp_load_ff <= 1'b0;
        sp_value_ff <= 16'h0000;
        vector_valid_ff <= 1'b0;
        vector_addr_ff <= 16'h0000;
    end
    else
    begin
        state_ff <= nxt_state;
        pri_stack_ff <= nxt_pri_stack;
        mem_wr_ff <= 1'b0;
        sp_load_ff <= 1'b0;
        vector_valid_ff <= 1'b0;
        if ((state_ff == ST_IDLE) && (nxt_state == ST_ACK))
        begin
            win_src_ff <= best_src;
            win_pri_ff <= best_pri;
            // The fetched byte is dropped; this address is refetched
            pc_hold_ff <= cpu_pc;
        end
        if (state_ff == ST_ACK)
        begin
            mem_wr_ff <= 1'b1;
            mem_addr_ff <= cpu_sp - `PIU_SP_HI_OFS;
            mem_wdata_ff <= pc_hold_ff[15:8];
        end
        if (state_ff == ST_PUSH_HI)
        begin
            mem_wr_ff <= 1'b1;
            mem_addr_ff <= cpu_sp - `PIU_SP_LO_OFS;
            mem_wdata_ff <= pc_hold_ff[7:0];
            sp_load_ff <= 1'b1;
            sp_value_ff <= cpu_sp - `PIU_SP_LO_OFS;
        end
        if (state_ff == ST_PUSH_LO)
        begin
            vector_valid_ff <= 1'b1;
            vector_addr_ff <= {vec_hi, vec_lo};
        end
    end
end

// ----------------------------------------------------------------
// Register file
// ----------------------------------------------------------------
always @(posedge sys_clk or negedge rstn)
begin
    if (!rstn)
    begin
        ext0_ctl_ff <= `PIU_CTL_RST;
        ext1_ctl_ff <= `PIU_CTL_RST;
        ext_base_ff <= `PIU_BASE_RST;
        int_base_ff <= `PIU_BASE_RST;
        rdata_ff <= 8'h00;
    end
    else
    begin
        if (reg_wr)
        begin
            case (reg_addr)
                `PIU_ADDR_EXT0_CTL: ext0_ctl_ff <= reg_wdata[5:0];
                `PIU_ADDR_EXT1_CTL: ext1_ctl_ff <= reg_wdata[5:0];
                `PIU_ADDR_EXT_BASE: ext_base_ff <= reg_wdata;
                `PIU_ADDR_INT_BASE: int_base_ff <= reg_wdata;
                default: ;
            endcase
        end
        rdata_ff <= 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `PIU_ADDR_EXT0_CTL: rdata_ff <= {2'b00, ext0_ctl_ff};
                `PIU_ADDR_EXT1_CTL: rdata_ff <= {2'b00, ext1_ctl_ff};
                `PIU_ADDR_EXT_BASE: rdata_ff <= ext_base_ff;
                `PIU_ADDR_INT_BASE: rdata_ff <= int_base_ff;
                `PIU_ADDR_PRI_STACK: rdata_ff <= pri_stack_ff;
                `PIU_ADDR_STATUS: rdata_ff <= {caught, (state_ff != ST_IDLE),
                                               best_valid, ext1_req, ext0_req};
                default: rdata_ff <= 8'h00;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign reg_rdata = rdata_ff;
assign ack_cycle = (state_ff == ST_ACK);
assign ack_refetch = (state_ff == ST_ACK);
assign mem_wr = mem_wr_ff;
assign mem_addr = mem_addr_ff;
assign mem_wdata = mem_wdata_ff;
assign sp_load = sp_load_ff;
assign sp_value = sp_value_ff;
assign vector_valid = vector_valid_ff;
assign vector_addr = vector_addr_ff;
assign cur_priority = cur_pri;

endmodule // piu_top
`default_nettype wire

/* testbench/piu_asserts.sv */
// Port assertions for the priority interrupt unit
`timescale 1ns/100ps
`default_nettype none
module piu_checker
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Sequencer side
    input wire logic fetch1_done,
    input wire logic [15:0] cpu_pc,
    input wire logic [15:0] cpu_sp,
    input wire logic ack_cycle,
    input wire logic ack_refetch,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic sp_load,
    input wire logic [15:0] sp_value,
    input wire logic vector_valid,
    input wire logic [15:0] vector_addr,
    input wire logic [1:0] cur_priority
);
    default clocking dck @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // ----
    // Steps of the acknowledge sequence
    // ----
    sequence push_hi;
        mem_wr && !sp_load && mem_addr == cpu_sp - 16'h1
            && mem_wdata == $past(cpu_pc[15:8], 2);
    endsequence
    sequence push_lo;
        mem_wr && sp_load && mem_addr == cpu_sp - 16'h2
            && sp_value == cpu_sp - 16'h2
            && mem_wdata == $past(cpu_pc[7:0], 3);
    endsequence
    AST_CALL_SEQ: assert property (
        ack_cycle |=> push_hi ##1 push_lo ##1 vector_valid)
        else $error("acknowledge not followed by two pushes and vector");
    AST_ACK_FETCH: assert property (ack_cycle |-> $past(fetch1_done))
        else $error("acknowledge without preceding opcode fetch");
    AST_REFETCH: assert property (ack_refetch == ack_cycle)
        else $error("refetch flag differs from acknowledge");
    AST_ACK_ONCE: assert property (ack_cycle |=> !ack_cycle [*4])
        else $error("second acknowledge inside a sequence");
    AST_PRI_RAISE: assert property (
        vector_valid |-> cur_priority > $past(cur_priority, 4))
        else $error("priority not raised by taken interrupt");
    AST_NOT_AT_TOP: assert property (
        ack_cycle |-> $past(cur_priority) != 2'h3)
        else $error("interrupt taken at top priority");
    AST_VEC_STEP: assert property (
        vector_valid |-> (vector_addr[3:0] == 4'h0
            || vector_addr[7:0] == 8'h08) && vector_addr[7:0] <= 8'hb0)
        else $error("vector low byte off the table grid");
    AST_WR_CAUSE: assert property (
        mem_wr |-> $past(ack_cycle) || $past(mem_wr))
        else $error("stack write outside a sequence");
endmodule // piu_checker
`default_nettype wire

/* testbench/piu_partner.sv */
// Processor sequencer model issuing opcode fetches
`timescale 1ns/100ps
`default_nettype none
module piu_partner
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control and handshake
    input wire logic run,
    input wire logic ack_cycle,
    input wire logic vector_valid,
    // Fetch side
    output logic fetch1_done,
    output logic [15:0] cpu_pc,
    output logic [15:0] cpu_sp
);
    logic [1:0] gap_ff;
    logic busy_ff;
    assign cpu_sp = 16'h7f00;
    // Fetch every fourth cycle, none inside a sequence
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gap_ff <= 2'h0;
            busy_ff <= 1'b0;
            fetch1_done <= 1'b0;
            cpu_pc <= 16'h1000;
        end
        else
        begin
            gap_ff <= gap_ff + 2'h1;
            fetch1_done <= 1'b0;
            if (ack_cycle)
                busy_ff <= 1'b1;
            if (vector_valid)
                busy_ff <= 1'b0;
            if (run && !busy_ff && !ack_cycle && gap_ff == 2'h3)
            begin
                fetch1_done <= 1'b1;
                cpu_pc <= cpu_pc + 16'h3;
            end
        end
    end
endmodule // piu_partner
`default_nettype wire

/* testbench/priority_interrupt_unit_test.sv */
// Self-checking bench for the priority interrupt unit
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_unit_test;
    logic sys_clk, rstn, reg_wr, reg_rd, run, pri_pop, fetch1_done;
    logic ack_cycle, vector_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0] pin;
    logic [2:0] m;
    logic [11:0] int_req;
    logic [23:0] int_pri;
    logic [15:0] cpu_pc, cpu_sp, vector_addr;
    logic [1:0] cur_priority;
    int error_cnt, checks_done;
    piu_top u_dut (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq_zero_first_pin(pin[0]),
        .irq_zero_second_pin(pin[1]), .irq_one_first_pin(pin[2]),
        .irq_one_second_pin(pin[3]), .int_req, .int_pri, .fetch1_done,
        .pri_pop, .cpu_pc, .cpu_sp, .ack_cycle, .ack_refetch(),
        .mem_wr(), .mem_addr(), .mem_wdata(), .sp_load(), .sp_value(),
        .vector_valid, .vector_addr, .cur_priority);
    piu_partner u_cpu (.sys_clk, .rstn, .run, .ack_cycle, .vector_valid,
        .fetch1_done, .cpu_pc, .cpu_sp);
    // ----
    // Access and compare tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    // Let fetches run and watch for one vector
    task automatic take(input logic [15:0] exp, input logic want);
        logic seen;
        logic [15:0] v;
        int i;
        seen = 1'b0;
        v = 16'h0;
        @(posedge sys_clk) run <= 1'b1;
        for (i = 0; i < 40 && !seen; i++)
        begin
            @(negedge sys_clk);
            seen = (vector_valid === 1'b1);
            v = vector_addr;
        end
        @(posedge sys_clk) run <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk({15'h0, seen}, {15'h0, want});
        if (want)
            chk(v, exp);
        if (want && !seen)
            finish_test();
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        rstn = 1'b0;
        {reg_wr, reg_rd, run, pri_pop} = 4'h0;
        {reg_addr, reg_wdata} = 16'h0;
        pin = 4'h0;
        int_req = 12'h0;
        int_pri = 24'h0;
        error_cnt = 0;
        checks_done = 0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdc(8'h9e, 8'hff);
        rdc(8'h9c, 8'h00);
        rdc(8'h9d, 8'h00);
        chk(cur_priority, 2'h3);
        rdc(8'h90, 8'h00);
        wr(8'h98, 8'hff);
        rdc(8'h98, 8'h3f);
        wr(8'h9c, 8'h40);
        wr(8'h9d, 8'h80);
        $display("test registers done");
        for (m = 3'h0; m < 3'h4; m++)
        begin
            wr(8'h9e, 8'hff);
            wr(8'h98, {4'h0, m[1:0], 2'h1});
            @(posedge sys_clk) pin[0] <= 1'b1;
            repeat (8) @(posedge sys_clk);
            rd(8'h9f, d);
            chk(d[0], m[1]);
            @(posedge sys_clk) pin[0] <= 1'b0;
            repeat (8) @(posedge sys_clk);
            rd(8'h9f, d);
            chk(d[0], m != 3'h0);
            wr(8'h9e, 8'hfc);
            take(16'h4000, m != 3'h0);
            rd(8'h9f, d);
            chk(d[0], 1'b0);
        end
        $display("test edge selection done");
        wr(8'h9e, 8'hff);
        wr(8'h98, 8'h22);
        wr(8'h99, 8'h3a);
        @(posedge sys_clk) pin[3:1] <= 3'h7;
        repeat (8) @(posedge sys_clk);
        wr(8'h9e, 8'hfc);
        take(16'h4008, 1'b1);
        wr(8'h9e, 8'hfc);
        take(16'h4000, 1'b1);
        wr(8'h9e, 8'hfc);
        take(16'h0, 1'b0);
        $display("test external pairs done");
        @(posedge sys_clk) int_pri <= 24'haaaaaa;
        int_req <= 12'h005;
        wr(8'h9e, 8'hfc);
        take(16'h8000, 1'b1);
        @(posedge sys_clk) int_req[0] <= 1'b0;
        wr(8'h9e, 8'hfc);
        take(16'h8020, 1'b1);
        @(posedge sys_clk) int_req <= 12'h801;
        int_pri[23:22] <= 2'h3;
        wr(8'h9e, 8'hfc);
        take(16'h80b0, 1'b1);
        @(negedge sys_clk) chk(cur_priority, 2'h3);
        @(posedge sys_clk) pri_pop <= 1'b1;
        @(posedge sys_clk) pri_pop <= 1'b0;
        @(negedge sys_clk) chk(cur_priority, 2'h0);
        @(posedge sys_clk) int_req <= 12'h008;
        int_pri <= 24'h000040;
        wr(8'h9e, 8'hfd);
        take(16'h0, 1'b0);
        wr(8'h9e, 8'hfc);
        take(16'h8030, 1'b1);
        @(posedge sys_clk) int_pri <= 24'h000c00;
        int_req <= 12'h020;
        @(posedge sys_clk) int_req <= 12'h000;
        wr(8'h9e, 8'hfc);
        take(16'h0, 1'b0);
        $display("test internal sources done");
        finish_test();
    end
endmodule // priority_interrupt_unit_test
bind piu_top piu_checker u_chk (.sys_clk, .rstn, .fetch1_done, .cpu_pc,
    .cpu_sp, .ack_cycle, .ack_refetch, .mem_wr, .mem_addr, .mem_wdata,
    .sp_load, .sp_value, .vector_valid, .vector_addr, .cur_priority);
`default_nettype wire
